// ===== quadrature_position_velocity.sv
// Local design decisions: the address map and the APB register port.
`timescale 1ns/1ps
// Behaviour
// - Flag phase error when both channels change in quadrature mode
// - Four interrupt sources: error, direction, timer, index
// - Only enabled sources reach the interrupt line
// - Raw and masked status both readable
// - Clear selected sources, others keep state
// - Module disable stops decoding and counting
// - Position count always readable
// - Software write loads position counter
// - Predivide increments by 1 to 128
// - Store count at period end, clear accumulator
// - Velocity read returns last completed period
// - Separate velocity enable gates accumulation, timing
// - Each source raised by its event
// - Select capture, index reset, mode, swap
// - Reverse index loads maximum position
// - Hold last direction after motion stops
module quadrature_position_velocity #(
   parameter int POS_W = 32
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        phase_a_input,
   input  wire logic        phase_b_input,
   input  wire logic        index_input,
   output logic             irq
);
   logic [8:0]             ctrl;
   logic [POS_W-1:0]       position;
   logic [POS_W-1:0]       max_position;
   logic [31:0]            period;
   logic [31:0]            period_count;
   logic [31:0]            vel_accum;
   logic [31:0]            vel_result;
   logic [6:0]             prediv_count;
   logic [3:0]             int_en;
   logic [3:0]             int_raw;
   logic                   phase_error;
   logic                   direction;
   logic [2:0]             pins_sync;
   logic [2:0]             pins_prev;

   // Input synchroniser
   qei_input_sync #(.WIDTH(3)) u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in ({index_input, phase_b_input, phase_a_input}),
      .sync_out (pins_sync)
   );

   // Bus decode
   wire access     = psel && penable;
   wire wr         = access && pwrite;
   wire hit_ctrl   = (paddr == qei_pkg::OFF_CTRL);
   wire hit_status = (paddr == qei_pkg::OFF_STATUS);
   wire hit_pos    = (paddr == qei_pkg::OFF_POS);
   wire hit_maxpos = (paddr == qei_pkg::OFF_MAXPOS);
   wire hit_load   = (paddr == qei_pkg::OFF_LOAD);
   wire hit_period = (paddr == qei_pkg::OFF_PERIOD);
   wire hit_vel    = (paddr == qei_pkg::OFF_VEL);
   wire hit_velrun = (paddr == qei_pkg::OFF_VEL_RUN);
   wire hit_inten  = (paddr == qei_pkg::OFF_INT_EN);
   wire hit_intraw = (paddr == qei_pkg::OFF_INT_RAW);
   wire hit_intmsk = (paddr == qei_pkg::OFF_INT_MASK);
   wire hit_intclr = (paddr == qei_pkg::OFF_INT_CLR);
   wire mapped     = hit_ctrl || hit_status || hit_pos || hit_maxpos ||
                     hit_load || hit_period || hit_vel || hit_velrun ||
                     hit_inten || hit_intraw || hit_intmsk || hit_intclr;
   wire load_pos   = wr && (hit_load || hit_pos);

   assign pready  = 1'b1;
   assign pslverr = access && !mapped;

   // Control fields
   wire enable     = ctrl[qei_pkg::CTRL_ENABLE];
   wire capture_ab = ctrl[qei_pkg::CTRL_CAPTURE_AB];
   wire reset_on_index = ctrl[qei_pkg::CTRL_RESET_IDX];
   wire clock_dir  = ctrl[qei_pkg::CTRL_CLOCK_DIR];
   wire swap       = ctrl[qei_pkg::CTRL_SWAP];
   wire vel_en     = ctrl[qei_pkg::CTRL_VEL_EN];
   wire [2:0] prediv_sel = ctrl[qei_pkg::CTRL_PREDIV_LSB +: 3];

   // Swap channels ahead of decoding
   wire chan_a      = swap ? pins_sync[1] : pins_sync[0];
   wire chan_b      = swap ? pins_sync[0] : pins_sync[1];
   wire chan_a_prev = swap ? pins_prev[1] : pins_prev[0];
   wire chan_b_prev = swap ? pins_prev[0] : pins_prev[1];
   wire a_edge   = chan_a ^ chan_a_prev;
   wire b_edge   = chan_b ^ chan_b_prev;
   wire idx_rise = pins_sync[2] && !pins_prev[2];

   // Both channels moving in one sample is illegal in phase mode
   wire err_event = enable && !clock_dir && a_edge && b_edge;

   // Quadrature: forward when A leads B; clock/dir: B gives direction
   wire quad_fwd  = a_edge ? (chan_a != chan_b) : (chan_a == chan_b);
   wire step_q    = !clock_dir && !err_event &&
                    (a_edge || (capture_ab && b_edge));
   wire step_c    = clock_dir && chan_a && !chan_a_prev;
   wire step      = enable && (step_q || step_c);
   wire step_fwd  = clock_dir ? !chan_b : quad_fwd;

   // Wrap between zero and maximum
   wire [POS_W-1:0] pos_up = (position >= max_position) ? '0
                             : position + 1'b1;
   wire [POS_W-1:0] pos_dn = (position == '0) ? max_position
                             : position - 1'b1;
   wire idx_event = enable && idx_rise;
   wire dir_event = step && (step_fwd != direction);

   // Predivided velocity pulse: masked counter wraps at 2^sel
   wire [6:0] prediv_mask = 7'((8'h01 << prediv_sel) - 8'h01);
   wire       vel_pulse   = step && vel_en &&
                            ((prediv_count & prediv_mask) == prediv_mask);
   wire       period_end  = enable && vel_en &&
                            (period_count + 32'h0000_0001 >= period);

   // Configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl         <= qei_pkg::CTRL_RESET;
         max_position <= POS_W'(qei_pkg::MAXPOS_RESET);
         period       <= qei_pkg::PERIOD_RESET;
         int_en       <= 4'h0;
      end else if (wr) begin
         if (hit_ctrl)   ctrl         <= pwdata[8:0];
         if (hit_maxpos) max_position <= pwdata[POS_W-1:0];
         if (hit_period) period       <= pwdata;
         if (hit_inten)  int_en       <= pwdata[3:0];
      end
   end

   // Position counter and direction
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         position  <= '0;
         direction <= 1'b0;
         pins_prev <= 3'h0;
      end else begin
         pins_prev <= pins_sync;
         if (load_pos) begin
            position <= pwdata[POS_W-1:0];
         end else if (idx_event && reset_on_index) begin
            position <= direction ? max_position : '0;
         end else if (step) begin
            position <= step_fwd ? pos_up : pos_dn;
         end
         if (step) begin
            direction <= !step_fwd;
         end
      end
   end

   // Velocity timer, predivider and accumulator
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         period_count <= qei_pkg::WORD_RESET;
         vel_accum    <= qei_pkg::WORD_RESET;
         vel_result   <= qei_pkg::WORD_RESET;
         prediv_count <= 7'h00;
      end else if (!(enable && vel_en)) begin
         period_count <= qei_pkg::WORD_RESET;
         vel_accum    <= qei_pkg::WORD_RESET;
         prediv_count <= 7'h00;
      end else begin
         if (step) begin
            prediv_count <= prediv_count + 7'h01;
         end
         if (period_end) begin
            period_count <= qei_pkg::WORD_RESET;
            vel_result   <= vel_accum + {31'h0, vel_pulse};
            vel_accum    <= qei_pkg::WORD_RESET;
         end else begin
            period_count <= period_count + 32'h0000_0001;
            vel_accum    <= vel_accum + {31'h0, vel_pulse};
         end
      end
   end

   // Event vector; a set in the clear cycle wins
   wire [3:0] int_set = {err_event, dir_event, period_end, idx_event};
   wire [3:0] int_clr = (wr && hit_intclr) ? pwdata[3:0] : 4'h0;
   wire [3:0] int_masked = int_raw & int_en;

   // Sticky interrupt status and error flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_raw     <= 4'h0;
         phase_error <= 1'b0;
         irq         <= 1'b0;
      end else begin
         int_raw <= (int_raw & ~int_clr) | int_set;
         irq     <= |(((int_raw & ~int_clr) | int_set) & int_en);
         if (err_event) begin
            phase_error <= 1'b1;
         end else if (int_clr[qei_pkg::IRQ_ERROR]) begin
            phase_error <= 1'b0;
         end
      end
   end

   // Read data mux
   wire [31:0] status_word = {29'h0, phase_error, direction, enable};
   wire [31:0] rd_mux =
      hit_ctrl   ? {23'h0, ctrl} :
      hit_status ? status_word :
      (hit_pos || hit_load) ? 32'(position) :
      hit_maxpos ? 32'(max_position) :
      hit_period ? period :
      hit_vel    ? vel_result :
      hit_velrun ? vel_accum :
      hit_inten  ? {28'h0, int_en} :
      hit_intraw ? {28'h0, int_raw} :
      hit_intmsk ? {28'h0, int_masked} :
      32'h0000_0000;

   // Registered read data, updated during the setup phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= qei_pkg::WORD_RESET;
      end else if (psel && !pwrite && !penable) begin
         prdata <= rd_mux;
      end
   end
endmodule

// ===== qei_pkg.sv
package qei_pkg;

   // Register byte offsets
   localparam logic [7:0] OFF_CTRL      = 8'h00;
   localparam logic [7:0] OFF_STATUS    = 8'h04;
   localparam logic [7:0] OFF_POS       = 8'h08;
   localparam logic [7:0] OFF_MAXPOS    = 8'h0c;
   localparam logic [7:0] OFF_LOAD      = 8'h10;
   localparam logic [7:0] OFF_PERIOD    = 8'h14;
   localparam logic [7:0] OFF_VEL       = 8'h18;
   localparam logic [7:0] OFF_VEL_RUN   = 8'h1c;
   localparam logic [7:0] OFF_INT_EN    = 8'h20;
   localparam logic [7:0] OFF_INT_RAW   = 8'h24;
   localparam logic [7:0] OFF_INT_MASK  = 8'h28;
   localparam logic [7:0] OFF_INT_CLR   = 8'h2c;

   // Control field positions
   localparam int CTRL_ENABLE     = 0;
   localparam int CTRL_CAPTURE_AB = 1;
   localparam int CTRL_RESET_IDX  = 2;
   localparam int CTRL_CLOCK_DIR  = 3;
   localparam int CTRL_SWAP       = 4;
   localparam int CTRL_VEL_EN     = 5;
   localparam int CTRL_PREDIV_LSB = 6;
   localparam int CTRL_WIDTH      = 9;

   // Interrupt bit positions
   localparam int IRQ_INDEX  = 0;
   localparam int IRQ_TIMER  = 1;
   localparam int IRQ_DIR    = 2;
   localparam int IRQ_ERROR  = 3;
   localparam int IRQ_COUNT  = 4;

   // Reset values
   localparam logic [8:0]  CTRL_RESET   = 9'h000;
   localparam logic [31:0] WORD_RESET   = 32'h0000_0000;
   localparam logic [31:0] MAXPOS_RESET = 32'hffff_ffff;
   localparam logic [31:0] PERIOD_RESET = 32'h0000_0001;

endpackage

// ===== qei_input_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for a group of encoder pins
module qei_input_sync #(
   parameter int WIDTH = 3
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;

   // First stage feeds only the second stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage1   <= '0;
         sync_out <= '0;
      end else begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end
endmodule

// ===== qei_checker.sv
`timescale 1ns/1ps
// Watches the block's pins; shadows what software wrote over the bus
module qei_checker (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        phase_a_input,
   input wire logic        phase_b_input,
   input wire logic        index_input,
   input wire logic        irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic        en_q;
   logic        vel_seen;
   logic        pos_ok;
   logic [3:0]  en_irq;
   logic [31:0] pos_w;
   // Decoded bus transfers
   wire acc = psel && penable;
   wire wr  = acc && pwrite;
   wire rd  = acc && !pwrite;
   wire wr_ctrl = wr && paddr == qei_pkg::OFF_CTRL;
   wire wr_pos  = wr && paddr == qei_pkg::OFF_POS;
   // Shadow state; a load only stays trusted while counting is off
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_q     <= 1'b0;
         vel_seen <= 1'b0;
         pos_ok   <= 1'b0;
         en_irq   <= 4'h0;
         pos_w    <= 32'h0;
      end else begin
         if (wr_ctrl) en_q <= pwdata[0];
         if (wr_ctrl && pwdata[5]) vel_seen <= 1'b1;
         if (wr && paddr == qei_pkg::OFF_INT_EN) en_irq <= pwdata[3:0];
         if (wr_pos) pos_w <= pwdata;
         if (wr_pos) pos_ok <= !en_q;
         else if (wr_ctrl && pwdata[0]) pos_ok <= 1'b0;
      end
   end
   chk_pos_load:
   assert property (rd && paddr == qei_pkg::OFF_POS && pos_ok
                    |-> prdata == pos_w) else $error("position not loaded");
   chk_irq_masked:
   assert property (irq |-> $past(en_irq) != 4'h0)
      else $error("irq with no source enabled");
   chk_mask_subset:
   assert property (rd && paddr == qei_pkg::OFF_INT_MASK
                    |-> (prdata[3:0] & ~en_irq) == 4'h0)
      else $error("masked status shows a disabled source");
   chk_reset_quiet:
   assert property ($rose(presetn) |-> !irq && prdata == 32'h0)
      else $error("outputs not cleared by reset");
   chk_ready_high:
   assert property (acc |-> pready) else $error("read stalled");
   chk_map_error:
   assert property (acc && paddr[1:0] == 2'b00
                    |-> pslverr == (paddr > 8'h2c))
      else $error("error response wrong for address");
   chk_vel_idle:
   assert property (rd && !vel_seen && (paddr == qei_pkg::OFF_VEL ||
                    paddr == qei_pkg::OFF_VEL_RUN) |-> prdata == 32'h0)
      else $error("velocity moved while never enabled");
   chk_status_en:
   assert property (rd && paddr == qei_pkg::OFF_STATUS |-> prdata[0] == en_q)
      else $error("status enable differs from control");
   cover property (rd && paddr == qei_pkg::OFF_POS && pos_ok);
   cover property (irq);
   cover property (wr && paddr == qei_pkg::OFF_INT_CLR);
endmodule

// ===== encoder_model.sv
`timescale 1ns/1ps
// Encoder stand-in: step pulses, index pulses and phase glitches
module encoder_model (
   input  wire logic pclk,
   output logic      pha,
   output logic      phb,
   output logic      idx
);
   initial begin
      pha = 1'b0;
      phb = 1'b0;
      idx = 1'b0;
   end
   // Direction settles before the step edge; idle gap lets sync catch up
   task automatic pulse(input logic rev, input logic ix);
      @(posedge pclk);
      phb <= rev;
      repeat (2) @(posedge pclk);
      if (ix) idx <= 1'b1;
      else pha <= 1'b1;
      repeat (2) @(posedge pclk);
      pha <= 1'b0;
      idx <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask
   // One full quadrature cycle; forward when A leads B
   task automatic quad_cycle(input logic rev);
      @(posedge pclk);
      if (rev) phb <= 1'b1;
      else pha <= 1'b1;
      repeat (3) @(posedge pclk);
      if (rev) pha <= 1'b1;
      else phb <= 1'b1;
      repeat (3) @(posedge pclk);
      if (rev) phb <= 1'b0;
      else pha <= 1'b0;
      repeat (3) @(posedge pclk);
      if (rev) pha <= 1'b0;
      else phb <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask
   // Both phases move on one edge: an illegal transition
   task automatic glitch();
      @(posedge pclk);
      pha <= ~pha;
      phb <= ~phb;
      repeat (4) @(posedge pclk);
   endtask
endmodule

// ===== tb_top.sv
`timescale 1ns/1ps
module tb_top;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic        pready;
   logic        pslverr;
   logic        pha;
   logic        phb;
   logic        idx;
   logic        irq;
   int          fails = 0;
   int          checks = 0;

   // System clock, 10 ns period
   always #5 pclk = ~pclk;

   encoder_model enc (.pclk(pclk), .pha(pha), .phb(phb), .idx(idx));

   quadrature_position_velocity dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .phase_a_input(pha), .phase_b_input(phb),
      .index_input(idx), .irq(irq));

   task automatic report_and_stop();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // One bus transfer; request held until ready is seen
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin
         fails++;
         report_and_stop();
      end
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask

   // Polling is bounded so a dead timer cannot hang the run
   task automatic wait_timer();
      int n;
      n = 0;
      apb(1'b1, qei_pkg::OFF_INT_CLR, 32'h2);
      do begin
         apb(1'b0, qei_pkg::OFF_INT_RAW, 32'h0);
         n++;
      end while (rd[1] !== 1'b1 && n < 600);
      if (n >= 600) begin
         fails++;
         report_and_stop();
      end
      apb(1'b1, qei_pkg::OFF_INT_CLR, 32'h2);
   endtask

   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rdc(qei_pkg::OFF_MAXPOS, qei_pkg::MAXPOS_RESET);
      rdc(qei_pkg::OFF_PERIOD, qei_pkg::PERIOD_RESET);
      rdc(qei_pkg::OFF_VEL, 32'h0);
      rdc(8'h30, 32'h0);
      // Configure first, then count through both wrap points
      apb(1'b1, qei_pkg::OFF_MAXPOS, 32'h9);
      apb(1'b1, qei_pkg::OFF_POS, 32'h8);
      apb(1'b1, qei_pkg::OFF_CTRL, 32'h9);
      repeat (3) enc.pulse(1'b0, 1'b0);
      rdc(qei_pkg::OFF_POS, 32'h1);
      repeat (2) enc.pulse(1'b1, 1'b0);
      rdc(qei_pkg::OFF_POS, 32'h9);
      apb(1'b1, qei_pkg::OFF_CTRL, 32'h8);
      enc.pulse(1'b0, 1'b0);
      rdc(qei_pkg::OFF_POS, 32'h9);
      rdc(qei_pkg::OFF_STATUS, 32'h2);
      apb(1'b1, qei_pkg::OFF_POS, 32'h3);
      rdc(qei_pkg::OFF_POS, 32'h3);
      // Index in reverse loads the maximum, forward clears
      apb(1'b1, qei_pkg::OFF_CTRL, 32'hd);
      enc.pulse(1'b1, 1'b1);
      rdc(qei_pkg::OFF_POS, 32'h9);
      apb(1'b1, qei_pkg::OFF_POS, 32'h5);
      enc.pulse(1'b0, 1'b0);
      enc.pulse(1'b0, 1'b1);
      rdc(qei_pkg::OFF_POS, 32'h0);
      rdc(qei_pkg::OFF_INT_RAW, 32'h5);
      rdc(qei_pkg::OFF_INT_MASK, 32'h0);
      chk(irq, 32'h0);
      apb(1'b1, qei_pkg::OFF_INT_EN, 32'h4);
      rdc(qei_pkg::OFF_INT_MASK, 32'h4);
      chk(irq, 32'h1);
      apb(1'b1, qei_pkg::OFF_INT_CLR, 32'h4);
      rdc(qei_pkg::OFF_INT_RAW, 32'h1);
      chk(irq, 32'h0);
      // Both phases change together in quadrature mode
      apb(1'b1, qei_pkg::OFF_INT_EN, 32'h8);
      apb(1'b1, qei_pkg::OFF_CTRL, 32'h1);
      enc.glitch();
      enc.glitch(); // Second toggle brings both pins back low
      apb(1'b0, qei_pkg::OFF_STATUS, 32'h0);
      chk(rd & 32'h4, 32'h4);
      chk(irq, 32'h1);
      apb(1'b1, qei_pkg::OFF_INT_CLR, 32'h8);
      apb(1'b0, qei_pkg::OFF_STATUS, 32'h0);
      chk(rd & 32'h4, 32'h0);
      // Quadrature decoding: both edges, swapped, then A only
      apb(1'b1, qei_pkg::OFF_POS, 32'h0);
      apb(1'b1, qei_pkg::OFF_CTRL, 32'h3);
      enc.quad_cycle(1'b0);
      rdc(qei_pkg::OFF_POS, 32'h4);
      apb(1'b1, qei_pkg::OFF_CTRL, 32'h13);
      enc.quad_cycle(1'b0);
      rdc(qei_pkg::OFF_POS, 32'h0);
      apb(1'b1, qei_pkg::OFF_CTRL, 32'h1);
      enc.quad_cycle(1'b1);
      rdc(qei_pkg::OFF_POS, 32'h8);
      // Every predivider: 128 steps inside one period
      apb(1'b1, qei_pkg::OFF_PERIOD, 32'h4b0);
      for (int d = 0; d < 8; d++) begin
         apb(1'b1, qei_pkg::OFF_CTRL, {23'h0, d[2:0], 6'h09});
         apb(1'b1, qei_pkg::OFF_CTRL, {23'h0, d[2:0], 6'h29});
         wait_timer();
         repeat (128) enc.pulse(1'b0, 1'b0);
         wait_timer();
         rdc(qei_pkg::OFF_VEL, 32'h80 >> d);
      end
      report_and_stop();
   end
endmodule

bind quadrature_position_velocity qei_checker chk_i (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .phase_a_input(phase_a_input),
   .phase_b_input(phase_b_input), .index_input(index_input), .irq(irq));
